// >>> common/pwt_pkg.sv
// package: register map, field layout and constants of the wake timer
package pwt_pkg;
    // ************************************************************
    // register offsets (byte addresses are four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_PERIOD_EXP    = 8'h14; // exponent
    localparam logic [7:0] IDX_PERIOD_MANT_H = 8'h15; // mantissa high
    localparam logic [7:0] IDX_PERIOD_MANT_L = 8'h16; // mantissa low
    localparam logic [7:0] IDX_COUNT_H       = 8'h17; // live count high
    localparam logic [7:0] IDX_COUNT_L       = 8'h18; // live count low
    localparam logic [7:0] IDX_CONTROL       = 8'h20; // enables, selects
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'h21; // sticky events
    localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h22; // interrupt mask
    localparam logic [7:0] IDX_IRQ_CLEAR     = 8'h23; // write one clears
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [4:0]  RST_EXPONENT = 5'h03;
    localparam logic [15:0] RST_MANTISSA = 16'h0000;
    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int CTL_TIMER_EN   = 0; // timer enable
    localparam int CTL_SLEEP      = 1; // chip in sleep
    localparam int CTL_XTAL_SEL   = 2; // external low-frequency crystal
    localparam int CTL_GPIO_WAKE  = 3; // gpio pin set to timer function
    localparam int CTL_WIDTH      = 4;
    // status: bit 0 expiry event
    localparam int IRQ_EXPIRY     = 0;
    localparam int IRQ_WIDTH      = 1;
    // each mantissa unit is 32 * 2^exponent ticks of the low-frequency clock
    localparam int TICKS_PER_UNIT_LOG2 = 5;
endpackage : pwt_pkg

// >>> rtl/pwt_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module pwt_sync
(
    input  wire logic clk,   // system clock
    input  wire logic rst,   // synchronous reset
    input  wire logic din,   // asynchronous level
    output logic      dout   // synchronised level
);
    logic meta_q; // first stage, read only by the second
    // ************************************************************
    // two stages
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : pwt_sync
`default_nettype wire

// >>> rtl/pwt_timer.sv
// periodic wake timer with apb register slave
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - counts internal rc low-frequency clock by default
// - counts programmed period when enabled in sleep
// - expiry raises interrupt request if enabled
// - live 16-bit count readable, high byte first
// - period is 32 times mantissa times two^exponent
// - enabled interrupt drives pin low, wakes oscillator
// - masked interrupt signals on gpio, keeps state
// - crystal select repurposes gpio0 as crystal pin
// - crystal select clocks timer from external crystal
module pwt_timer
(
    input  wire logic        clk,           // system clock, 25 MHz
    input  wire logic        rst,           // synchronous, active high
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [11:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error
    input  wire logic        rcClk,         // internal rc 32.768 kHz
    input  wire logic        xtalClk,       // external crystal on gpio0
    output logic             interruptRequestN, // active-low request pin
    output logic             gpioWake,      // gpio timer function output
    output logic             gpio0XtalMode, // gpio0 given to crystal
    output logic             lowFreqClk,    // selected low-freq clock
    output logic             mainOscWake,   // main oscillator request
    output logic             irq            // level interrupt
);
    import pwt_pkg::*;

    // ************************************************************
    // apb decode
    // ************************************************************
    logic [7:0] regIdx;              // word index
    logic       wrEn;                // write strobe
    logic       rdEn;                // read strobe
    logic       addrOk;              // mapped address
    assign regIdx  = paddr[9:2];
    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && penable && !pwrite;
    assign pready  = 1'b1;           // zero wait state slave
    assign pslverr = psel && penable && !addrOk;

    always_comb
    begin
        // alignment and upper bits first, then the word must be mapped
        addrOk = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
        case (regIdx)
            IDX_PERIOD_EXP, IDX_PERIOD_MANT_H, IDX_PERIOD_MANT_L,
            IDX_COUNT_H, IDX_COUNT_L, IDX_CONTROL, IDX_IRQ_STATUS,
            IDX_IRQ_ENABLE, IDX_IRQ_CLEAR:
                ;                    // mapped word keeps the test
            default: addrOk = 1'b0;  // unmapped word
        endcase
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [4:0]            exponent_q;   // period exponent
    logic [15:0]           mantissa_q;   // period mantissa
    logic [CTL_WIDTH-1:0]  control_q;    // enable and select bits
    logic [IRQ_WIDTH-1:0]  irqEnable_q;  // interrupt mask

    // software writes land only in the access phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            exponent_q  <= RST_EXPONENT;
            mantissa_q  <= RST_MANTISSA;
            control_q   <= '0;
            irqEnable_q <= '0;
        end
        else if (wrEn && addrOk)
        begin
            case (regIdx)
                IDX_PERIOD_EXP:    exponent_q        <= pwdata[4:0];
                IDX_PERIOD_MANT_H: mantissa_q[15:8]  <= pwdata[7:0];
                IDX_PERIOD_MANT_L: mantissa_q[7:0]   <= pwdata[7:0];
                IDX_CONTROL:       control_q   <= pwdata[CTL_WIDTH-1:0];
                IDX_IRQ_ENABLE:    irqEnable_q <= pwdata[IRQ_WIDTH-1:0];
                default:           ;     // read-only or clear
            endcase
        end
    end

    logic timerEn;   // timer enable bit
    logic sleeping;  // chip in sleep
    logic xtalSel;   // external crystal chosen
    logic gpioFunc;  // gpio set to timer function
    assign timerEn  = control_q[CTL_TIMER_EN];
    assign sleeping = control_q[CTL_SLEEP];
    assign xtalSel  = control_q[CTL_XTAL_SEL];
    assign gpioFunc = control_q[CTL_GPIO_WAKE];

    // gpio0 becomes the crystal pin while the select bit is set
    assign gpio0XtalMode = xtalSel;

    // ************************************************************
    // low-frequency clock sampling
    // ************************************************************
    logic rcSync;    // rc clock in system domain
    logic xtalSync;  // crystal clock in system domain

    pwt_sync uRcSync
    (
        .clk  (clk),
        .rst  (rst),
        .din  (rcClk),
        .dout (rcSync)
    );

    pwt_sync uXtalSync
    (
        .clk  (clk),
        .rst  (rst),
        .din  (xtalClk),
        .dout (xtalSync)
    );

    logic lfSel_q;   // selected source, registered
    logic lfPrev_q;  // previous level for edge detect
    logic lfTick;    // one pulse per low-frequency rising edge

    // rc by default, crystal only when selected; the 25 MHz clock
    // oversamples the 32 kHz source by far, so no edge is lost
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lfSel_q  <= 1'b0;
            lfPrev_q <= 1'b0;
        end
        else
        begin
            lfSel_q  <= xtalSel ? xtalSync : rcSync;
            lfPrev_q <= lfSel_q;
        end
    end
    assign lfTick     = lfSel_q && !lfPrev_q;
    assign lowFreqClk = lfSel_q;

    // ************************************************************
    // wake period counter
    // ************************************************************
    // the count register shows mantissa units; a prescaler of
    // 32 * 2^exponent ticks sits in front of it
    logic [35:0] prescale_q;  // ticks within one mantissa unit
    logic [35:0] unitTicks;   // ticks per unit
    logic [15:0] count_q;     // live count, mantissa units
    logic        running;     // timer active
    logic        unitDone;    // one mantissa unit elapsed
    logic        expiry;      // period complete, one pulse

    assign unitTicks = 36'h1 << (TICKS_PER_UNIT_LOG2 + int'(exponent_q));
    assign running   = timerEn && sleeping;
    assign unitDone  = lfTick && (prescale_q == unitTicks - 36'h1);
    // a zero mantissa never expires
    assign expiry    = running && unitDone && (mantissa_q != 16'h0)
                       && (count_q == mantissa_q - 16'h1);

    // leaving sleep clears the count as well, so a host that wants
    // the live value must read it while the timer still runs
    always_ff @(posedge clk)
    begin
        if (rst || !running)
        begin
            prescale_q <= '0;   // entering sleep starts a fresh period
            count_q    <= '0;
        end
        else if (lfTick)
        begin
            if (unitDone)
            begin
                prescale_q <= '0;
                // restart from zero after expiry
                count_q <= expiry ? 16'h0 : count_q + 16'h1;
            end
            else
            begin
                prescale_q <= prescale_q + 36'h1;
            end
        end
    end

    // ************************************************************
    // interrupt status and outputs
    // ************************************************************
    logic [IRQ_WIDTH-1:0] irqStatus_q;  // sticky events
    logic                 clrHit;       // clear write or status read
    logic [IRQ_WIDTH-1:0] clrMask;      // bits to clear

    // reading status clears it, as does the clear register;
    // a new expiry in the same cycle wins over the clear
    assign clrHit  = psel && penable && addrOk &&
                     ((rdEn && regIdx == IDX_IRQ_STATUS) ||
                      (wrEn && regIdx == IDX_IRQ_CLEAR));
    assign clrMask = !clrHit ? '0 :
                     (rdEn ? '1 : pwdata[IRQ_WIDTH-1:0]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqStatus_q <= '0;
        end
        else
        begin
            irqStatus_q[IRQ_EXPIRY] <= expiry ||
                (irqStatus_q[IRQ_EXPIRY] && !clrMask[IRQ_EXPIRY]);
        end
    end

    logic irqLevel;   // enabled pending event
    assign irqLevel = |(irqStatus_q & irqEnable_q);

    logic irqN_q;     // registered pin
    logic gpio_q;     // registered gpio output
    logic wake_q;     // main oscillator request

    // pin and oscillator request follow the enabled status
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqN_q <= 1'b1;
            gpio_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            irqN_q <= !irqLevel;
            // masked path: gpio shows expiry, no state change
            if (!irqEnable_q[IRQ_EXPIRY] && gpioFunc && expiry)
                gpio_q <= 1'b1;
            else if (clrMask[IRQ_EXPIRY] || !gpioFunc)
                gpio_q <= 1'b0;
            wake_q <= irqLevel;
        end
    end
    assign interruptRequestN = irqN_q;
    assign gpioWake          = gpio_q;
    assign mainOscWake       = wake_q;
    assign irq               = irqLevel;

    // ************************************************************
    // read data
    // ************************************************************
    logic [31:0] rdata_d;  // selected read word
    always_comb
    begin
        rdata_d = 32'h0;
        case (regIdx)
            IDX_PERIOD_EXP:    rdata_d[4:0] = exponent_q;
            IDX_PERIOD_MANT_H: rdata_d[7:0] = mantissa_q[15:8];
            IDX_PERIOD_MANT_L: rdata_d[7:0] = mantissa_q[7:0];
            IDX_COUNT_H:       rdata_d[7:0] = count_q[15:8];
            IDX_COUNT_L:       rdata_d[7:0] = count_q[7:0];
            IDX_CONTROL:       rdata_d[CTL_WIDTH-1:0] = control_q;
            IDX_IRQ_STATUS:    rdata_d[IRQ_WIDTH-1:0] = irqStatus_q;
            IDX_IRQ_ENABLE:    rdata_d[IRQ_WIDTH-1:0] = irqEnable_q;
            default:           rdata_d = 32'h0;
        endcase
    end
    assign prdata = (rdEn && addrOk) ? rdata_d : 32'h0;

    // ************************************************************
    // checks
    // ************************************************************
    a_irq_pin_low: assert property (@(posedge clk) disable iff (rst)
        irqLevel |=> !interruptRequestN)
        else $error("request pin not low after enabled event");
    a_expiry_sets_stat: assert property (@(posedge clk) disable iff (rst)
        expiry |=> irqStatus_q[IRQ_EXPIRY])
        else $error("expiry did not set status");
    a_idle_no_count: assert property (@(posedge clk) disable iff (rst)
        !running |=> count_q == 16'h0)
        else $error("count moved while not running");
    a_restart_zero: assert property (@(posedge clk) disable iff (rst)
        expiry |=> count_q == 16'h0 && prescale_q == 36'h0)
        else $error("counter did not restart after expiry");
    a_expiry_at_period: assert property (@(posedge clk) disable iff (rst)
        expiry |-> count_q == mantissa_q - 16'h1)
        else $error("expiry not at programmed period");
    a_wake_request: assert property (@(posedge clk) disable iff (rst)
        irqLevel |=> mainOscWake)
        else $error("main oscillator not requested");
    a_gpio_masked: assert property (@(posedge clk) disable iff (rst)
        (expiry && gpioFunc && !irqEnable_q[IRQ_EXPIRY])
        |=> gpioWake && interruptRequestN)
        else $error("masked expiry not shown on gpio only");
    a_count_read: assert property (@(posedge clk) disable iff (rst)
        (rdEn && regIdx == IDX_COUNT_L && paddr[1:0] == 2'b00
         && paddr[11:10] == 2'b00) |-> prdata[7:0] == count_q[7:0])
        else $error("count low byte misread");
    a_xtal_source: assert property (@(posedge clk) disable iff (rst)
        xtalSel |=> lfSel_q == $past(xtalSync))
        else $error("crystal not used as source");
endmodule : pwt_timer
`default_nettype wire

// >>> verification/pwt_host_model.sv
// host model: apb master and interrupt service of the wake timer
`timescale 1ns/10ps
`default_nettype none
module pwt_host_model
(
    input  wire logic        clk,               // system clock
    output logic             psel,              // apb select
    output logic             penable,           // apb access phase
    output logic             pwrite,            // apb direction
    output logic      [11:0] paddr,             // apb byte address
    output logic      [31:0] pwdata,            // apb write data
    input  wire logic [31:0] prdata,            // apb read data
    input  wire logic        pready,            // apb ready
    input  wire logic        pslverr,           // apb error
    input  wire logic        interruptRequestN  // active-low request pin
);
    import pwt_pkg::*;
    // ************************************************************
    // bus idle from time zero
    // ************************************************************
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end
    // one transfer: setup, then access held until pready is sampled
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no wait count assumed: only the bench watchdog ends this
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // confirm the source; the read also clears the pending event
    task automatic service_irq(output logic [31:0] status);
        logic err;
        xfer(1'b0, IDX_IRQ_STATUS, 32'h0, status, err);
    endtask : service_irq
endmodule : pwt_host_model
`default_nettype wire

// >>> verification/pwt_timer_tb.sv
// self-checking bench of the periodic wake timer
`timescale 1ns/10ps
`default_nettype none
module pwt_timer_tb;
    import pwt_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic        clk = 1'b0;       // system clock, 40 ns
    logic        rst = 1'b1;       // synchronous reset
    logic        psel;             // apb from host model
    logic        penable;          // apb access
    logic        pwrite;           // apb direction
    logic [11:0] paddr;            // apb address
    logic [31:0] pwdata;           // apb write data
    logic [31:0] prdata;           // apb read data
    logic        pready;           // apb ready
    logic        pslverr;          // apb error
    logic        rcClk = 1'b0;     // rc low-frequency source
    logic        xtalClk = 1'b0;   // crystal low-frequency source
    logic        rcRun = 1'b1;     // rc source toggling
    logic        xtalRun = 1'b0;   // crystal source toggling
    logic [2:0]  lfDiv = 3'h0;     // divider for the scaled sources
    logic        interruptRequestN; // request pin
    logic        gpioWake;         // gpio timer output
    logic        gpio0XtalMode;    // gpio0 given to crystal
    logic        mainOscWake;      // oscillator wake request
    logic        lowFreqClk;       // selected low-frequency clock
    logic        irq;              // level interrupt
    logic [31:0] rdData;           // last read data
    logic        rdErr;            // last error flag
    int          miscompares = 0;  // mismatches seen
    int          checks = 0;       // comparisons made
    int          n;                // measured cycles
    // ************************************************************
    // clock and low-frequency sources
    // ************************************************************
    always #20 clk = ~clk;
    // sources scaled to 10 system cycles so periods fit the run
    always @(posedge clk)
    begin
        lfDiv <= (lfDiv == 3'h4) ? 3'h0 : lfDiv + 3'h1;
        if (lfDiv == 3'h4)
        begin
            if (rcRun) rcClk <= ~rcClk;
            if (xtalRun) xtalClk <= ~xtalClk;
        end
    end
    pwt_timer dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rcClk(rcClk),
        .xtalClk(xtalClk), .interruptRequestN(interruptRequestN),
        .gpioWake(gpioWake), .gpio0XtalMode(gpio0XtalMode),
        .lowFreqClk(lowFreqClk), .mainOscWake(mainOscWake), .irq(irq));
    pwt_host_model host_u (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .interruptRequestN(interruptRequestN));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check
    function automatic logic [31:0] in_range(int v, int lo, int hi);
        return {31'h0, (v >= lo && v <= hi)};
    endfunction : in_range
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host_u.xfer(1'b1, idx, d, rdData, rdErr);
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        host_u.xfer(1'b0, idx, 32'h0, rdData, rdErr);
    endtask : rd
    // fresh start, rc source only; reset spans the synchronisers
    task automatic do_reset;
        @(posedge clk);
        rst     <= 1'b1;
        rcRun   <= 1'b1;
        xtalRun <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    // cycles until the pin falls, or the gpio output rises
    task automatic wait_evt(input bit useGpio, output int cnt);
        cnt = 0;
        while (((useGpio ? gpioWake : ~interruptRequestN) !== 1'b1)
               && cnt < 3000)
        begin
            @(posedge clk);
            cnt++;
        end
    endtask : wait_evt
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        do_reset;
        rd(IDX_PERIOD_EXP);
        check(rdData, 32'h00000003);
        rd(IDX_PERIOD_MANT_H);
        check(rdData, 32'h00000000);
        wr(IDX_PERIOD_MANT_H, 32'h000000ab);
        rd(IDX_PERIOD_MANT_H);
        check(rdData, 32'h000000ab);
        wr(IDX_COUNT_L, 32'h000000ff);
        rd(IDX_COUNT_L);
        check(rdData, 32'h00000000);
        rd(8'h30);
        check({rdData[30:0], rdErr}, 32'h00000001);
    endtask : t_regs
    // one mantissa unit, exponent 1: 64 source edges per period
    task automatic t_period;
        do_reset;
        wr(IDX_PERIOD_MANT_L, 32'h1);
        wr(IDX_PERIOD_EXP, 32'h1);
        wr(IDX_IRQ_ENABLE, 32'h1);
        wr(IDX_CONTROL, 32'h3);
        wait_evt(1'b0, n);
        check(in_range(n, 620, 665), 32'h1);
        check({31'h0, mainOscWake}, 32'h1);
        check({31'h0, irq}, 32'h1);
        host_u.service_irq(rdData);
        check(rdData, 32'h00000001);
        repeat (3) @(posedge clk);
        check({31'h0, interruptRequestN}, 32'h1);
        wait_evt(1'b0, n);
        check(in_range(n, 600, 665), 32'h1);
    endtask : t_period
    // masked event shows on the gpio output only, and stays
    task automatic t_gpio;
        do_reset;
        wr(IDX_PERIOD_MANT_L, 32'h1);
        wr(IDX_PERIOD_EXP, 32'h0);
        wr(IDX_CONTROL, 32'hb);
        wait_evt(1'b1, n);
        check(in_range(n, 300, 335), 32'h1);
        repeat (50) @(posedge clk);
        check({29'h0, gpioWake, interruptRequestN, irq}, 32'h6);
        check({31'h0, mainOscWake}, 32'h0);
        wr(IDX_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, gpioWake}, 32'h0);
    endtask : t_gpio
    // about 70 edges of a 128-edge period: two mantissa units
    task automatic t_count;
        do_reset;
        wr(IDX_PERIOD_MANT_L, 32'h4);
        wr(IDX_PERIOD_EXP, 32'h0);
        wr(IDX_CONTROL, 32'h3);
        repeat (700) @(posedge clk);
        // read while running: the next unit ends some 250 cycles later
        rd(IDX_COUNT_H);
        check(rdData, 32'h00000000);
        rd(IDX_COUNT_L);
        check(rdData, 32'h00000002);
        // leaving sleep stops the timer and clears its count
        wr(IDX_CONTROL, 32'h1);
        rd(IDX_COUNT_L);
        check(rdData, 32'h00000000);
    endtask : t_count
    // rc stopped: only the crystal can make the timer expire
    task automatic t_xtal;
        do_reset;
        rcRun   <= 1'b0;
        xtalRun <= 1'b1;
        wr(IDX_PERIOD_MANT_L, 32'h1);
        wr(IDX_PERIOD_EXP, 32'h0);
        wr(IDX_IRQ_ENABLE, 32'h1);
        wr(IDX_CONTROL, 32'h7);
        // the write landed at the last edge of the transfer; look one edge later
        @(posedge clk);
        check({31'h0, gpio0XtalMode}, 32'h1);
        wait_evt(1'b0, n);
        check(in_range(n, 300, 335), 32'h1);
        // selected clock follows the crystal three cycles late
        @(xtalClk);
        repeat (4) @(posedge clk);
        check({31'h0, lowFreqClk}, {31'h0, xtalClk});
    endtask : t_xtal
    // ************************************************************
    // verdict, sequence and watchdog
    // ************************************************************
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    initial
    begin
        t_regs;
        t_period;
        t_gpio;
        t_count;
        t_xtal;
        print_verdict;
    end
    // about seven times the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict;
    end
endmodule : pwt_timer_tb
`default_nettype wire
